// >>> swt_pkg.sv
package swt_pkg;

	localparam logic [15:0] SWT_ADDR_PERIOD = 16'h2880;
	localparam logic [15:0] SWT_ADDR_FLAGS  = 16'h28b1;
	localparam logic [15:0] SWT_ADDR_CTRL   = 16'h28b2;

	localparam int SWT_BIT_TMR_FLAG = 2;
	localparam int SWT_BIT_SLEEP    = 7;
	localparam int SWT_BIT_DISPLAY  = 6;
	localparam int SWT_BIT_ARM      = 5;

	localparam int SWT_CRYSTAL_HZ = 32768;

	typedef enum logic [1:0]
	{
		SWT_AWAKE   = 2'h0,
		SWT_DISPLAY = 2'h1,
		SWT_SLEEP   = 2'h2
	} swt_mode_t;

	typedef struct packed
	{
		logic        wr;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} swt_req_t;

endpackage

// >>> swt_sleep_wake_timer.sv
`timescale 1ns/10ps
module swt_sleep_wake_timer
	import swt_pkg::*;
#(
	parameter int CRYSTAL_HZ = SWT_CRYSTAL_HZ
)
(
	input  wire logic       core_clk,
	input  wire logic       reset,
	input  wire logic       slow_crystal_clock,
	input  wire swt_req_t   req,
	output      logic [7:0] rd_data,
	output      logic       wake,
	output      logic       cpu_hold_reset,
	output      swt_mode_t  power_mode
);

	////////////////////////////////////////////////////////////////////////////
	// Decode helpers

	// True when the request addresses the given register
	function automatic logic hits(input swt_req_t r, input logic [15:0] a);
		hits = (r.addr == a);
	endfunction

	// True when a control write carries the given bit
	function automatic logic ctrl_bit(input swt_req_t r, input int b);
		ctrl_bit = r.wr && hits(r, SWT_ADDR_CTRL) && r.wdata[b];
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Crystal clock sampling

	logic xtal_s1_r;
	logic xtal_s2_r;
	logic xtal_s3_r;
	wire  xtal_rise;

	// Two flops settle the asynchronous pin; the third only serves edge detection
	always_ff @(posedge core_clk)
	begin
		xtal_s1_r <= slow_crystal_clock;
		xtal_s2_r <= xtal_s1_r;
		xtal_s3_r <= xtal_s2_r;
	end

	assign xtal_rise = xtal_s2_r & ~xtal_s3_r;

	////////////////////////////////////////////////////////////////////////////
	// State

	logic [7:0]  period_r;
	logic        arm_r;
	logic        tmr_flag_r;
	logic [7:0]  count_r;
	logic [7:0]  rd_data_r;
	logic [31:0] prescale_r;
	swt_mode_t   mode_r;

	////////////////////////////////////////////////////////////////////////////
	// Register decode

	wire wr_period;
	wire wr_ctrl;
	wire req_sleep;
	wire req_disp;
	wire arm_write;
	wire is_awake;
	wire enter_low;
	wire counting;

	assign wr_period = req.wr && hits(req, SWT_ADDR_PERIOD);
	assign wr_ctrl   = req.wr && hits(req, SWT_ADDR_CTRL);
	assign req_sleep = ctrl_bit(req, SWT_BIT_SLEEP);
	assign req_disp  = ctrl_bit(req, SWT_BIT_DISPLAY);
	assign arm_write = ctrl_bit(req, SWT_BIT_ARM);
	assign is_awake  = (mode_r == SWT_AWAKE);
	assign enter_low = is_awake && (req_sleep || req_disp);
	assign counting  = !is_awake && arm_r;

	////////////////////////////////////////////////////////////////////////////
	// One-second tick from the crystal

	wire        last_phase;
	wire        second_tick;
	wire        expire;
	wire [31:0] prescale_nxt;

	assign last_phase  = (prescale_r == 32'(CRYSTAL_HZ - 1));
	assign second_tick = counting && xtal_rise && last_phase;
	assign expire      = second_tick && (count_r == 8'h00);

	// Restarting the prescaler on entry makes the timeout whole seconds
	assign prescale_nxt = enter_low                ? 32'h0 :
	                      !(counting && xtal_rise) ? prescale_r :
	                      last_phase               ? 32'h0 : prescale_r + 32'h1;

	////////////////////////////////////////////////////////////////////////////
	// Next values

	wire [7:0] count_nxt;
	wire       arm_nxt;
	wire       flag_nxt;

	assign count_nxt = (enter_low || expire)  ? period_r :
	                   (arm_write && is_awake) ? period_r :
	                   second_tick             ? count_r - 8'h01 : count_r;

	// Control writes are ignored while a low-power mode holds
	assign arm_nxt = (wr_ctrl && is_awake) ? req.wdata[SWT_BIT_ARM] : arm_r;

	// Set wins over clear, though the two cannot meet
	assign flag_nxt = expire    ? 1'b1 :
	                  enter_low ? 1'b0 : tmr_flag_r;

	swt_mode_t mode_nxt;

	// Sleep wins when both requests come together
	always_comb
	begin
		mode_nxt = mode_r;
		unique case (mode_r)
			SWT_AWAKE:
			begin
				if (req_sleep)
					mode_nxt = SWT_SLEEP;
				else if (req_disp)
					mode_nxt = SWT_DISPLAY;
			end
			SWT_DISPLAY, SWT_SLEEP:
			begin
				if (expire)
					mode_nxt = SWT_AWAKE;
			end
			default:
				mode_nxt = SWT_AWAKE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Read selection

	wire [7:0] ctrl_view;
	wire [7:0] flag_view;
	wire [7:0] rd_nxt;

	assign ctrl_view = (8'(mode_r == SWT_SLEEP) << SWT_BIT_SLEEP)
	                 | (8'(mode_r == SWT_DISPLAY) << SWT_BIT_DISPLAY)
	                 | (8'(arm_r) << SWT_BIT_ARM);
	assign flag_view = 8'(tmr_flag_r) << SWT_BIT_TMR_FLAG;
	assign rd_nxt    = hits(req, SWT_ADDR_PERIOD) ? period_r  :
	                   hits(req, SWT_ADDR_FLAGS)  ? flag_view :
	                   hits(req, SWT_ADDR_CTRL)   ? ctrl_view : 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// Period setting, no reset so it survives resets

	always_ff @(posedge core_clk)
	begin
		if (wr_period)
			period_r <= req.wdata;
	end

	////////////////////////////////////////////////////////////////////////////
	// Arm bit

	always_ff @(posedge core_clk)
	begin
		if (reset)
			arm_r <= 1'b0;
		else
			arm_r <= arm_nxt;
	end

	////////////////////////////////////////////////////////////////////////////
	// Power mode

	always_ff @(posedge core_clk)
	begin
		if (reset)
			mode_r <= SWT_AWAKE;
		else
			mode_r <= mode_nxt;
	end

	////////////////////////////////////////////////////////////////////////////
	// Timer wake flag

	always_ff @(posedge core_clk)
	begin
		if (reset)
			tmr_flag_r <= 1'b0;
		else
			tmr_flag_r <= flag_nxt;
	end

	////////////////////////////////////////////////////////////////////////////
	// Seconds counter

	always_ff @(posedge core_clk)
	begin
		if (reset)
			count_r <= 8'h00;
		else
			count_r <= count_nxt;
	end

	////////////////////////////////////////////////////////////////////////////
	// Crystal prescaler

	always_ff @(posedge core_clk)
	begin
		if (reset)
			prescale_r <= 32'h0;
		else
			prescale_r <= prescale_nxt;
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data

	always_ff @(posedge core_clk)
	begin
		if (reset)
			rd_data_r <= 8'h00;
		else
			rd_data_r <= rd_nxt;
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	// Low wake keeps the processor in reset until expiry
	assign wake           = is_awake;
	assign cpu_hold_reset = ~is_awake;
	assign power_mode     = mode_r;
	assign rd_data        = rd_data_r;

endmodule

// >>> swt_chk.sv
`timescale 1ns/10ps
module swt_chk
	import swt_pkg::*;
(
	input wire logic       core_clk,
	input wire logic       reset,
	input wire logic       slow_crystal_clock,
	input wire swt_req_t   req,
	input wire logic [7:0] rd_data,
	input wire logic       wake,
	input wire logic       cpu_hold_reset,
	input wire swt_mode_t  power_mode
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	wire ctl = req.wr && req.addr == SWT_ADDR_CTRL;
	hold_inv_a: assert property (cpu_hold_reset == !wake) else $error("hold");
	sleep_in_a: assert property (ctl && req.wdata[7] && wake |=> !wake && power_mode == SWT_SLEEP)
		else $error("sleep");
	disp_in_a: assert property (ctl && req.wdata[7:6] == 2'h1 && wake |=> power_mode == SWT_DISPLAY)
		else $error("disp");
	wake_hold_a: assert property (wake && !ctl |=> wake) else $error("drop");
	flag_clr_a: assert property (!wake && req.addr == SWT_ADDR_FLAGS |=> !rd_data[2])
		else $error("clr");
	flag_set_a: assert property ($rose(wake) && req.addr == SWT_ADDR_FLAGS |=> rd_data[2])
		else $error("set");
	period_rb_a: assert property (req.wr && req.addr == SWT_ADDR_PERIOD ##1 req.addr == SWT_ADDR_PERIOD
		|=> rd_data == $past(req.wdata, 2)) else $error("per");
	reset_state_a: assert property (disable iff (1'b0) reset |=> wake && power_mode == SWT_AWAKE)
		else $error("rst");
endmodule
bind swt_sleep_wake_timer swt_chk swt_chk_i (.*);

// >>> swt_cpu_model.sv
`timescale 1ns/10ps
module swt_cpu_model
(
	input  wire logic        core_clk,
	input  wire logic        cpu_hold_reset,
	output      logic [15:0] held_cycles = 16'h0000
);
	logic was_held_r = 1'b0;
	always_ff @(posedge core_clk)
	begin
		was_held_r <= cpu_hold_reset;
		if (cpu_hold_reset)
			held_cycles <= was_held_r ? held_cycles + 16'h0001 : 16'h0001;
	end
endmodule

// >>> testbench.sv
`timescale 1ns/10ps
module testbench
	import swt_pkg::*;
;
	logic       core_clk = 0, reset = 1, slow_crystal_clock = 0, wake, cpu_hold_reset;
	swt_req_t   req = '0;
	logic [7:0] rd_data;
	logic [15:0] held_cycles;
	swt_mode_t  power_mode;
	int         fails = 0, checked = 0;
	always #50 core_clk = ~core_clk;
	always #1000 slow_crystal_clock = ~slow_crystal_clock;
	swt_sleep_wake_timer #(.CRYSTAL_HZ(4)) swt_sleep_wake_timer_i
	(
		.core_clk           (core_clk),
		.reset              (reset),
		.slow_crystal_clock (slow_crystal_clock),
		.req                (req),
		.rd_data            (rd_data),
		.wake               (wake),
		.cpu_hold_reset     (cpu_hold_reset),
		.power_mode         (power_mode)
	);
	swt_cpu_model swt_cpu_model_i
	(
		.core_clk       (core_clk),
		.cpu_hold_reset (cpu_hold_reset),
		.held_cycles    (held_cycles)
	);
	task chk(input logic [7:0] s, e);
		checked++;
		if (s !== e)
		begin
			fails++;
			$display("MISMATCH t=%0t got %h exp %h", $time, s, e);
		end
	endtask
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge core_clk) req = '{1'b1, a, d};
		@(negedge core_clk) req.wr = 1'b0;
	endtask
	task rd(input logic [15:0] a, input logic [7:0] e);
		@(negedge core_clk) req.addr = a;
		@(negedge core_clk) chk(rd_data, e);
	endtask
	task report_and_stop;
		$display("fails=%0d checked=%0d", fails, checked);
		if (fails == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		#1000000 fails++;
		report_and_stop;
	end
	initial
	begin
		repeat (3) @(negedge core_clk);
		reset = 0;
		wr(SWT_ADDR_PERIOD, 8'h02);
		rd(SWT_ADDR_PERIOD, 8'h02);
		wr(SWT_ADDR_CTRL, 8'h20);
		repeat (60) @(negedge core_clk);
		chk(8'(wake), 8'h01);
		for (int i = 0; i < 2; i++)
		begin
			wr(SWT_ADDR_CTRL, i ? 8'h60 : 8'ha0);
			chk(8'(power_mode), i ? 8'(SWT_DISPLAY) : 8'(SWT_SLEEP));
			chk(8'(cpu_hold_reset), 8'h01);
			rd(SWT_ADDR_FLAGS, 8'h00);
			for (int k = 0; k < 400 && wake !== 1'b1; k++) @(negedge core_clk);
			chk(8'(held_cycles >= 220 && held_cycles <= 265), 8'h01);
			chk(8'(power_mode), 8'(SWT_AWAKE));
			rd(SWT_ADDR_FLAGS, 8'h04);
			rd(SWT_ADDR_CTRL, 8'h20);
			$display("wake test %0d done", i);
		end
		@(negedge core_clk) reset = 1;
		@(negedge core_clk) reset = 0;
		rd(SWT_ADDR_PERIOD, 8'h02);
		$display("reset test done");
		report_and_stop;
	end
endmodule
